// ===== timer16_device.sv
// Notes on behaviour
// - counter seen as low and high bytes
// - high-byte location touches only shared latch
// - low-byte read copies counter high into latch
// - low-byte write loads latch and byte together
// - each tick clears, increments or decrements
// - three-bit tick source select, zero stops
// - counter accessible with tick stopped
// - processor write beats counting in same cycle
// - four-bit waveform mode split over A and B
// - overflow flag per mode, can interrupt
// - top and bottom indications for other logic
// - capture on selected edge of pin/comparator
// - capture copies counter and sets flag together
// - capture enable bit gates capture interrupt
// - capture flag cleared by service or one
// - capture low read first, high from latch
// - capture writable only in capture-top modes
// - software writes high byte before low byte
// - main code masks interrupts around two bytes
// - latch keeps value after low-byte write
// - one latch shared by all wide registers
// - compare value bytes read directly
`timescale 1ns/1ns
`default_nettype none
`include "timer16_defines.svh"

module timer16_device
  import timer16_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // processor side
  timer16_if.dev bus,
  // pins from outside the clock domain
  input wire logic capture_pin_i,
  input wire logic comparator_output_i,
  input wire logic ext_tick_i,
  // indications for other timer functions
  output logic top_o,
  output logic bottom_o
);

  // count limit of the selected waveform mode
  function automatic logic [15:0] mode_top(input logic [3:0] m,
    input logic [15:0] icr, input logic [15:0] ocr);
    case (m)
      4'h1, 4'h5: mode_top = `TOP_8BIT;
      4'h2, 4'h6: mode_top = `TOP_9BIT;
      4'h3, 4'h7: mode_top = `TOP_10BIT;
      4'h4, 4'h9, 4'hb, 4'hf: mode_top = ocr;
      4'h8, 4'ha, 4'hc, 4'he: mode_top = icr;
      default: mode_top = `TOP_MAX;
    endcase
  endfunction

  // dual-slope modes count up to top and back to bottom
  function automatic logic mode_updown(input logic [3:0] m);
    case (m)
      4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb: mode_updown = 1'b1;
      default: mode_updown = 1'b0;
    endcase
  endfunction

  // modes in which the capture register is the count limit
  function automatic logic mode_icr_top(input logic [3:0] m);
    case (m)
      4'h8, 4'ha, 4'hc, 4'he: mode_icr_top = 1'b1;
      default: mode_icr_top = 1'b0;
    endcase
  endfunction

  dev_state_s s_reg;
  dev_state_s s_next;
  logic [3:0] mode;
  logic [2:0] tsel;
  logic [15:0] top;
  logic ctc;
  logic tick;
  logic cap_edge;
  logic rd_op;
  logic wr_op;
  logic [1:0] set_flags;
  logic [1:0] clr_flags;

  // mode and tick decode
  assign mode = {s_reg.ctl_b[`CTLB_WGM_HI], s_reg.ctl_a[`CTLA_WGM_LO]};
  assign tsel = s_reg.ctl_b[`CTLB_TICK_SEL];
  assign top = mode_top(mode, s_reg.cap, s_reg.ocra);
  assign ctc = (mode == 4'h4) || (mode == 4'hc);
  assign rd_op = bus.rd && ce_i;
  assign wr_op = bus.wr && ce_i;

  // tick select; zero stops the counter entirely
  always_comb
  begin
    case (tsel)
      `TICK_CLK: tick = 1'b1;
      `TICK_DIV8: tick = (s_reg.presc[2:0] == 3'h0);
      `TICK_DIV64: tick = (s_reg.presc[5:0] == 6'h00);
      `TICK_DIV256: tick = (s_reg.presc[7:0] == 8'h00);
      `TICK_DIV1024: tick = (s_reg.presc == 10'h000);
      `TICK_EXT_FALL: tick = s_reg.ext_prev && !s_reg.ext_s2;
      `TICK_EXT_RISE: tick = !s_reg.ext_prev && s_reg.ext_s2;
      default: tick = 1'b0;
    endcase
  end

  // edge detector after the synchroniser; off in capture-top modes
  assign cap_edge = !mode_icr_top(mode) &&
    (s_reg.ctl_b[`CTLB_CAP_EDGE] ? (!s_reg.cap_prev && s_reg.cap_s2)
                                 : (s_reg.cap_prev && !s_reg.cap_s2));

  // next-state logic: counting, capture, then processor access on top
  always_comb
  begin
    s_next = s_reg;
    set_flags = 2'h0;
    clr_flags = 2'h0;
    // prescaler free-runs while any source is selected
    s_next.presc = (tsel == `TICK_STOP) ? 10'h000 : s_reg.presc + 10'h001;
    // source mux ahead of a two-stage synchroniser
    s_next.cap_s1 = s_reg.ctl_b[`CTLB_CAP_SRC] ? comparator_output_i
                                              : capture_pin_i;
    s_next.cap_s2 = s_reg.cap_s1;
    s_next.cap_prev = s_reg.cap_s2;
    s_next.ext_s1 = ext_tick_i;
    s_next.ext_s2 = s_reg.ext_s1;
    s_next.ext_prev = s_reg.ext_s2;
    // counting sequence
    if (tick)
    begin
      if (mode_updown(mode))
      begin
        if (!s_reg.dir_down && s_reg.cnt >= top)
        begin
          s_next.dir_down = 1'b1;
          s_next.cnt = s_reg.cnt - 16'h0001;
        end
        else if (s_reg.dir_down && s_reg.cnt == `BOTTOM)
        begin
          s_next.dir_down = 1'b0;
          s_next.cnt = s_reg.cnt + 16'h0001;
        end
        else if (s_reg.dir_down)
        begin
          s_next.cnt = s_reg.cnt - 16'h0001;
          set_flags[`IRQ_OVF] = (s_reg.cnt == 16'h0001);
        end
        else
          s_next.cnt = s_reg.cnt + 16'h0001;
      end
      else
      begin
        s_next.dir_down = 1'b0;
        // ctc clears at top but still flags overflow at max
        s_next.cnt = (s_reg.cnt == top) ? `BOTTOM : s_reg.cnt + 16'h0001;
        set_flags[`IRQ_OVF] = ctc ? (s_reg.cnt == `TOP_MAX)
                                  : (s_reg.cnt == top);
      end
    end
    // capture stamps the counter and raises its flag together
    if (cap_edge)
    begin
      s_next.cap = s_reg.cnt;
      set_flags[`IRQ_CAP] = 1'b1;
    end
    // processor reads: data registered, latch updated at same edge
    if (rd_op)
    begin
      case (bus.addr)
        `LOC_COUNT_LOW:
        begin
          s_next.rdata = s_reg.cnt[7:0];
          s_next.temp = s_reg.cnt[15:8];
        end
        `LOC_CAPTURE_LOW:
        begin
          s_next.rdata = s_reg.cap[7:0];
          s_next.temp = s_reg.cap[15:8];
        end
        `LOC_COUNT_HIGH, `LOC_CAPTURE_HIGH: s_next.rdata = s_reg.temp;
        `LOC_COMPARE_LOW: s_next.rdata = s_reg.ocra[7:0];
        `LOC_COMPARE_HIGH: s_next.rdata = s_reg.ocra[15:8];
        `LOC_CONTROL_A: s_next.rdata = s_reg.ctl_a;
        `LOC_CONTROL_B: s_next.rdata = s_reg.ctl_b;
        `LOC_IRQ_MASK: s_next.rdata = {6'h00, s_reg.mask};
        `LOC_IRQ_FLAGS: s_next.rdata = {6'h00, s_reg.flags};
        default: s_next.rdata = 8'h00;
      endcase
    end
    // processor writes; a counter write overrides counting
    if (wr_op)
    begin
      case (bus.addr)
        `LOC_COUNT_HIGH, `LOC_CAPTURE_HIGH, `LOC_COMPARE_HIGH:
          s_next.temp = bus.wdata;
        `LOC_COUNT_LOW:
          s_next.cnt = {s_reg.temp, bus.wdata};
        `LOC_CAPTURE_LOW:
          if (mode_icr_top(mode))
            s_next.cap = {s_reg.temp, bus.wdata};
        `LOC_COMPARE_LOW: s_next.ocra = {s_reg.temp, bus.wdata};
        `LOC_CONTROL_A: s_next.ctl_a = bus.wdata;
        `LOC_CONTROL_B: s_next.ctl_b = bus.wdata;
        `LOC_IRQ_MASK: s_next.mask = bus.wdata[1:0];
        `LOC_IRQ_FLAGS: clr_flags = bus.wdata[1:0];
        default: ;
      endcase
    end
    // service acknowledge clears too; a new event wins over any clear
    if (ce_i)
    begin
      clr_flags[`IRQ_OVF] = clr_flags[`IRQ_OVF] | bus.ack_ovf;
      clr_flags[`IRQ_CAP] = clr_flags[`IRQ_CAP] | bus.ack_cap;
    end
    s_next.flags = (s_reg.flags & ~clr_flags) | set_flags;
  end

  // single state register; enable freezes everything
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_reg <= '0;
    end
    else if (ce_i)
    begin
      s_reg <= s_next;
    end
  end

  // outputs
  assign bus.rdata = s_reg.rdata;
  assign bus.irq_ovf = s_reg.flags[`IRQ_OVF] && s_reg.mask[`IRQ_OVF];
  assign bus.irq_cap = s_reg.flags[`IRQ_CAP] && s_reg.mask[`IRQ_CAP];
  assign top_o = (s_reg.cnt == top);
  assign bottom_o = (s_reg.cnt == `BOTTOM);

endmodule

`default_nettype wire

// ===== timer16_defines.svh
`ifndef TIMER16_DEFINES_SVH
`define TIMER16_DEFINES_SVH

// device byte locations on the 8-bit processor bus
`define LOC_COUNT_LOW    4'h0
`define LOC_COUNT_HIGH   4'h1
`define LOC_CAPTURE_LOW  4'h2
`define LOC_CAPTURE_HIGH 4'h3
`define LOC_COMPARE_LOW  4'h4
`define LOC_COMPARE_HIGH 4'h5
`define LOC_CONTROL_A    4'h6
`define LOC_CONTROL_B    4'h7
`define LOC_IRQ_MASK     4'h8
`define LOC_IRQ_FLAGS    4'h9

// field positions in timer_control_a / timer_control_b
`define CTLA_WGM_LO   1:0
`define CTLB_TICK_SEL 2:0
`define CTLB_WGM_HI   4:3
`define CTLB_CAP_SRC  5
`define CTLB_CAP_EDGE 6

// bit positions in flag and mask registers
`define IRQ_OVF 0
`define IRQ_CAP 1

// reset values
`define RST_BYTE  8'h00
`define RST_WORD  16'h0000
`define RST_FLAGS 2'h0

// fixed count limits
`define TOP_MAX   16'hffff
`define TOP_8BIT  16'h00ff
`define TOP_9BIT  16'h01ff
`define TOP_10BIT 16'h03ff
`define BOTTOM    16'h0000

// tick source codes and prescaler taps
`define TICK_STOP     3'h0
`define TICK_CLK      3'h1
`define TICK_DIV8     3'h2
`define TICK_DIV64    3'h3
`define TICK_DIV256   3'h4
`define TICK_DIV1024  3'h5
`define TICK_EXT_FALL 3'h6
`define TICK_EXT_RISE 3'h7
`define PRESC_W       10

// wishbone word map of the controller
`define WB_COUNT   3'h0
`define WB_CAPTURE 3'h1
`define WB_COMPARE 3'h2
`define WB_CTLA    3'h3
`define WB_CTLB    3'h4
`define WB_MASK    3'h5
`define WB_FLAGS   3'h6
`define WB_SERVICE 3'h7

`endif

// ===== timer16_pkg.sv
package timer16_pkg;

  typedef struct packed {
    logic [15:0] cnt;
    logic dir_down;
    logic [7:0] temp;
    logic [15:0] cap;
    logic [15:0] ocra;
    logic [7:0] ctl_a;
    logic [7:0] ctl_b;
    logic [1:0] mask;
    logic [1:0] flags;
    logic [9:0] presc;
    logic cap_s1;
    logic cap_s2;
    logic cap_prev;
    logic ext_s1;
    logic ext_s2;
    logic ext_prev;
    logic [7:0] rdata;
  } dev_state_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OP1  = 3'b001,
    ST_OP2  = 3'b010,
    ST_GET  = 3'b011,
    ST_ACK  = 3'b100
  } host_state_e;

  typedef struct packed {
    host_state_e st;
    logic [3:0] adr;
    logic [7:0] wd;
    logic wr;
    logic rd;
    logic ack_ovf;
    logic ack_cap;
    logic [15:0] data;
    logic wide;
    logic is_read;
    logic [3:0] hi_adr;
    logic [7:0] wlow;
  } host_state_s;

endpackage

// ===== timer16_if.sv
`timescale 1ns/1ns
`default_nettype none

interface timer16_if;
  // byte-wide processor bus
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic wr;
  logic rd;
  // interrupt requests and service acknowledges
  logic irq_ovf;
  logic irq_cap;
  logic ack_ovf;
  logic ack_cap;

  modport dev (
    input addr, wdata, wr, rd, ack_ovf, ack_cap,
    output rdata, irq_ovf, irq_cap
  );
  modport host (
    output addr, wdata, wr, rd, ack_ovf, ack_cap,
    input rdata, irq_ovf, irq_cap
  );
endinterface

`default_nettype wire

// ===== timer16_host.sv
`timescale 1ns/1ns
`default_nettype none
`include "timer16_defines.svh"

module timer16_host
  import timer16_pkg::*;
#(
  parameter int ADR_W = 6
)
(
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // combined interrupt request
  output logic irq_o,
  // device side
  timer16_if.host bus
);

  generate
    if (ADR_W < 6)
    begin : g_bad_adr
      $error("timer16_host: ADR_W must be at least 6");
    end
  endgenerate

  // low and high byte locations of a wishbone word
  function automatic logic [7:0] byte_locs(input logic [2:0] idx);
    case (idx)
      `WB_COUNT: byte_locs = {`LOC_COUNT_HIGH, `LOC_COUNT_LOW};
      `WB_CAPTURE: byte_locs = {`LOC_CAPTURE_HIGH, `LOC_CAPTURE_LOW};
      `WB_COMPARE: byte_locs = {`LOC_COMPARE_HIGH, `LOC_COMPARE_LOW};
      `WB_CTLA: byte_locs = {4'h0, `LOC_CONTROL_A};
      `WB_CTLB: byte_locs = {4'h0, `LOC_CONTROL_B};
      `WB_MASK: byte_locs = {4'h0, `LOC_IRQ_MASK};
      `WB_FLAGS: byte_locs = {4'h0, `LOC_IRQ_FLAGS};
      default: byte_locs = 8'h00;
    endcase
  endfunction

  host_state_s s_reg;
  host_state_s s_next;
  logic req;
  logic [2:0] idx;
  logic mapped;
  logic [7:0] locs;

  assign req = cyc_i && stb_i;
  assign idx = adr_i[4:2];
  assign mapped = (adr_i[ADR_W-1:5] == '0);
  assign locs = byte_locs(idx);

  // each wishbone word becomes up to two byte cycles, never split
  always_comb
  begin
    s_next = s_reg;
    s_next.wr = 1'b0;
    s_next.rd = 1'b0;
    s_next.ack_ovf = 1'b0;
    s_next.ack_cap = 1'b0;
    case (s_reg.st)
      ST_IDLE:
        if (req)
        begin
          s_next.wide = (idx <= `WB_COMPARE);
          s_next.is_read = !we_i;
          // second byte location: high byte for reads, low byte for writes
          s_next.hi_adr = we_i ? locs[3:0] : locs[7:4];
          s_next.wlow = dat_i[7:0];
          s_next.data = 16'h0000;
          s_next.st = ST_ACK;
          if (!mapped)
            s_next.st = ST_ACK;
          else if (idx == `WB_SERVICE)
          begin
            // service word: read pending requests, write ones to retire
            if (we_i)
            begin
              s_next.ack_ovf = sel_i[0] && dat_i[`IRQ_OVF];
              s_next.ack_cap = sel_i[0] && dat_i[`IRQ_CAP];
            end
            else
              s_next.data = {14'h0000, bus.irq_cap, bus.irq_ovf};
          end
          else if (!we_i)
          begin
            s_next.rd = 1'b1;
            s_next.adr = locs[3:0];
            s_next.st = ST_OP1;
          end
          else if (sel_i[1:0] != 2'h0)
          begin
            s_next.wr = 1'b1;
            s_next.adr = (idx <= `WB_COMPARE) ? locs[7:4] : locs[3:0];
            s_next.wd = (idx <= `WB_COMPARE) ? dat_i[15:8] : dat_i[7:0];
            s_next.st = ST_OP1;
          end
        end
      ST_OP1:
        if (s_reg.wide)
        begin
          // second byte follows at once, so nothing can slip between
          s_next.adr = s_reg.hi_adr;
          s_next.rd = s_reg.is_read;
          s_next.wr = !s_reg.is_read;
          s_next.wd = s_reg.wlow;
          s_next.st = ST_OP2;
        end
        else
          s_next.st = s_reg.is_read ? ST_GET : ST_ACK;
      ST_OP2:
        if (s_reg.is_read)
        begin
          s_next.data[7:0] = bus.rdata;
          s_next.st = ST_GET;
        end
        else
          s_next.st = ST_ACK;
      ST_GET:
      begin
        if (s_reg.wide)
          s_next.data[15:8] = bus.rdata;
        else
          s_next.data[7:0] = bus.rdata;
        s_next.st = ST_ACK;
      end
      ST_ACK: s_next.st = ST_IDLE;
      default: s_next.st = ST_IDLE;
    endcase
  end

  // single state register; enable freezes everything
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_reg <= '0;
    end
    else if (ce_i)
    begin
      s_reg <= s_next;
    end
  end

  // outputs
  assign dat_o = {16'h0000, s_reg.data};
  assign ack_o = req && (s_reg.st == ST_ACK);
  assign irq_o = bus.irq_ovf || bus.irq_cap;
  assign bus.addr = s_reg.adr;
  assign bus.wdata = s_reg.wd;
  assign bus.wr = s_reg.wr;
  assign bus.rd = s_reg.rd;
  assign bus.ack_ovf = s_reg.ack_ovf;
  assign bus.ack_cap = s_reg.ack_cap;

endmodule

`default_nettype wire

// ===== timer16_properties.sv
`timescale 1ns/1ns
`default_nettype none
`include "timer16_defines.svh"

module timer16_properties
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // byte bus between the two ends
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic wr,
  input wire logic rd,
  // interrupt lines and service pulses
  input wire logic irq_ovf,
  input wire logic irq_cap,
  input wire logic ack_ovf,
  input wire logic ack_cap,
  // counter indication
  input wire logic bottom_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // a wide counter write: high byte into the latch, then low byte commits
  sequence s_hi_wr;
    wr && addr == `LOC_COUNT_HIGH;
  endsequence
  sequence s_lo_wr;
    wr && addr == `LOC_COUNT_LOW;
  endsequence

  // low-byte writes must follow the matching high-byte write at once
  a_write_order: assert property (
    wr && (addr == `LOC_COUNT_LOW || addr == `LOC_CAPTURE_LOW ||
    addr == `LOC_COMPARE_LOW) |-> $past(wr) && $past(addr) == addr + 4'h1)
    else $error("low byte written without preceding high byte");
  // high-byte reads must follow the low-byte read that loads the latch
  a_read_order: assert property (
    rd && (addr == `LOC_COUNT_HIGH || addr == `LOC_CAPTURE_HIGH)
    |-> $past(rd) && $past(addr) == addr - 4'h1)
    else $error("high byte read without preceding low byte read");
  // the committed 16-bit value shows on the bottom indication
  a_wide_commit: assert property (
    s_hi_wr ##1 s_lo_wr |=>
    bottom_o == ($past(wdata, 2) == 8'h00 && $past(wdata) == 8'h00))
    else $error("counter not loaded from latch and low byte");
  // read data only moves after a read
  a_rdata_stands: assert property (!rd |=> $stable(rdata))
    else $error("read data changed without a read");
  // overflow request only at the wrap to bottom or on unmasking
  a_ovf_cause: assert property (
    $rose(irq_ovf) |-> bottom_o || $past(wr && addr == `LOC_IRQ_MASK))
    else $error("overflow request rose without wrap");
  // capture request only drops by service, reset, mask or flag write
  a_cap_fall: assert property (
    $fell(irq_cap) |-> $past(ack_cap || rst_i || (wr &&
    (addr == `LOC_IRQ_MASK || addr == `LOC_IRQ_FLAGS))))
    else $error("capture request dropped without cause");
  a_cap_service: assert property (ack_cap |=> !irq_cap)
    else $error("capture flag not cleared by service");
  a_ovf_service: assert property (ack_ovf |=> !irq_ovf)
    else $error("overflow flag not cleared by service");
endmodule

`default_nettype wire

// ===== timer16_counter_capture_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "timer16_defines.svh"

// compare, count, and report a mismatch
`define CHK(n, e, g) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) \
    begin \
      failures++; \
      $display("[FAIL] %s expected %h seen %h", n, e, g); \
    end \
  end

module timer16_counter_capture_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat_w = 32'h0;
  logic [31:0] dat_r;
  logic ack;
  logic irq;
  logic top;
  logic bottom;
  logic pin = 1'b0;
  logic cmp = 1'b0;
  logic [31:0] q;
  int failures = 0;
  int cmp_count = 0;

  timer16_if tif ();
  timer16_host timer16_host_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack), .irq_o(irq), .bus(tif.host));
  timer16_device timer16_device_inst (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(1'b1), .bus(tif.dev), .capture_pin_i(pin),
    .comparator_output_i(cmp), .ext_tick_i(1'b0), .top_o(top),
    .bottom_o(bottom));
  timer16_properties timer16_properties_inst (.clk_i(clk_i), .rst_i(rst_i),
    .addr(tif.addr), .wdata(tif.wdata), .rdata(tif.rdata), .wr(tif.wr),
    .rd(tif.rd), .irq_ovf(tif.irq_ovf), .irq_cap(tif.irq_cap),
    .ack_ovf(tif.ack_ovf), .ack_cap(tif.ack_cap), .bottom_o(bottom));

  // 25 MHz clock
  always #20 clk_i = ~clk_i;

  // one classic cycle; the request holds until ack is seen high or 64 edges pass
  task automatic wb(input logic w_en, input logic [5:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w_en;
    adr <= a;
    sel <= 4'hf;
    dat_w <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 64);
    q = dat_r;
    if (ack !== 1'b1)
    begin
      failures++;
      $display("[FAIL] ack expected 1 seen %b", ack);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  // word helpers: words sit on 4-byte steps
  task automatic wr_w(input logic [2:0] w, input logic [31:0] d);
    wb(1'b1, {1'b0, w, 2'b00}, d);
  endtask
  task automatic rd_w(input string n, input logic [2:0] w,
    input logic [31:0] e);
    wb(1'b0, {1'b0, w, 2'b00}, 32'h0);
    `CHK(n, e, q)
  endtask

  // set up a capture source and edge, then move the inputs
  task automatic edge_case(input string n, input logic [7:0] cb,
    input logic [15:0] cnt, input logic p, input logic c,
    input logic [31:0] fl);
    wr_w(`WB_CTLB, {24'h0, cb});
    wr_w(`WB_COUNT, {16'h0, cnt});
    wr_w(`WB_FLAGS, 32'h2);
    pin <= p;
    cmp <= c;
    repeat (6) @(posedge clk_i);
    rd_w(n, `WB_FLAGS, fl);
  endtask

  // run the counter on the system clock for a while, then check
  task automatic runchk(input string n, input logic [7:0] ca,
    input logic [7:0] cb, input logic [15:0] start, input logic [31:0] fl,
    input logic [15:0] lo, input logic [15:0] hi);
    wr_w(`WB_CTLA, {24'h0, ca});
    wr_w(`WB_CTLB, {24'h0, cb});
    wr_w(`WB_COUNT, {16'h0, start});
    wr_w(`WB_FLAGS, 32'h3);
    wr_w(`WB_CTLB, {24'h0, cb | 8'h01});
    repeat (30) @(posedge clk_i);
    wr_w(`WB_CTLB, {24'h0, cb});
    rd_w(n, `WB_FLAGS, fl);
    wb(1'b0, {1'b0, `WB_COUNT, 2'b00}, 32'h0);
    `CHK(n, 1'b1, (q[15:0] >= lo && q[15:0] <= hi))
  endtask

  task automatic tend(input string n);
    $display("test %s done", n);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // watchdog: the tests need a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge clk_i);
    failures++;
    wrap_up();
  end

  // test sequence
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    `CHK("bottom", 1'b1, bottom)
    `CHK("top", 1'b0, top)
    rd_w("count", `WB_COUNT, 32'h0);
    rd_w("control b", `WB_CTLB, 32'h0);
    rd_w("flags", `WB_FLAGS, 32'h0);
    wb(1'b0, 6'h20, 32'h0);
    `CHK("unmapped", 32'h0, q)
    tend("reset");
    wr_w(`WB_COUNT, 32'h01ff);
    `CHK("bottom", 1'b0, bottom)
    rd_w("count", `WB_COUNT, 32'h01ff);
    repeat (20) @(posedge clk_i);
    rd_w("stopped", `WB_COUNT, 32'h01ff);
    wr_w(`WB_COUNT, 32'h0);
    `CHK("bottom", 1'b1, bottom)
    wr_w(`WB_COMPARE, 32'h1234);
    rd_w("compare", `WB_COMPARE, 32'h1234);
    rd_w("count kept", `WB_COUNT, 32'h0);
    tend("wide access");
    wr_w(`WB_CAPTURE, 32'habcd);
    rd_w("capture mode 0", `WB_CAPTURE, 32'h0);
    wr_w(`WB_CTLB, 32'h18);
    wr_w(`WB_CAPTURE, 32'h0abc);
    rd_w("capture mode 12", `WB_CAPTURE, 32'h0abc);
    tend("capture write");
    wr_w(`WB_MASK, 32'h2);
    edge_case("pin rise", 8'h40, 16'h5555, 1'b1, 1'b0, 32'h2);
    `CHK("irq", 1'b1, irq)
    rd_w("capture", `WB_CAPTURE, 32'h5555);
    wr_w(`WB_SERVICE, 32'h2);
    // the flag clears at the ack edge itself; look one edge later
    @(posedge clk_i);
    `CHK("irq", 1'b0, irq)
    edge_case("fall ignored", 8'h40, 16'h1111, 1'b0, 1'b0, 32'h0);
    edge_case("rise ignored", 8'h00, 16'h2222, 1'b1, 1'b0, 32'h0);
    edge_case("pin fall", 8'h00, 16'h2222, 1'b0, 1'b0, 32'h2);
    rd_w("capture", `WB_CAPTURE, 32'h2222);
    edge_case("comparator", 8'h60, 16'h3333, 1'b0, 1'b1, 32'h2);
    rd_w("capture", `WB_CAPTURE, 32'h3333);
    wr_w(`WB_MASK, 32'h0);
    `CHK("irq masked", 1'b0, irq)
    rd_w("flag kept", `WB_FLAGS, 32'h2);
    wr_w(`WB_FLAGS, 32'h2);
    rd_w("flag cleared", `WB_FLAGS, 32'h0);
    cmp <= 1'b0;
    tend("capture");
    wr_w(`WB_MASK, 32'h1);
    runchk("normal", 8'h00, 8'h00, 16'hfff0, 32'h1, 16'h0, 16'h3f);
    `CHK("irq", 1'b1, irq)
    wr_w(`WB_SERVICE, 32'h1);
    @(posedge clk_i);
    `CHK("irq", 1'b0, irq)
    runchk("single", 8'h01, 8'h08, 16'h00f0, 32'h1, 16'h0, 16'h3f);
    runchk("dual", 8'h01, 8'h00, 16'h00f0, 32'h0, 16'h80, 16'hfe);
    tend("counting");
    wrap_up();
  end
endmodule

`default_nettype wire
